// ===== lift_controller.sv
// Lift-controller end: register-driven quickstart commands
`timescale 1ns/1ps
module lift_controller
  import quickstart_pkg::*;
#(
  parameter int unsigned TICK_DIV = MS_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  quickstart_if.lift       link,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  output logic             irq
);
  logic tick;
  ms_tick #(.DIV(TICK_DIV)) u_tick (.clk_sys(clk_sys), .srst(srst), .tick(tick));

  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [IRQ_W-1:0]  stat_reg, stat_next, mask_reg, mask_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic              irq_reg, irq_next;
  logic [1:0]        rdy_s, brk_s;
  logic              rdy_d_reg, brk_d_reg;
  logic [15:0]       late_ms_reg, late_ms_next;
  logic              wait_reg, wait_next;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdy_s <= 2'h0;
      brk_s <= 2'h0;
    end else begin
      rdy_s <= {rdy_s[0], link.drive_ready_out};
      brk_s <= {brk_s[0], link.brake_release_out};
    end
  end

  always_comb begin
    ctrl_next    = ctrl_reg;
    mask_next    = mask_reg;
    stat_next    = stat_reg;
    late_ms_next = late_ms_reg;
    wait_next    = wait_reg;
    rdata_next   = 32'h0;
    if (wr && addr == ADDR_CTRL) begin
      ctrl_next = wdata[CTRL_W-1:0];
      // Hold dropped: start the speed-select deadline
      if (ctrl_reg[CTRL_HOLD] && !wdata[CTRL_HOLD]) begin
        wait_next    = 1'b1;
        late_ms_next = 16'h0;
      end
      // Speed bits except readjust only once hold is off
      if (wdata[CTRL_HOLD]) begin
        ctrl_next[CTRL_POS]   = 1'b0;
        ctrl_next[CTRL_INTER] = 1'b0;
        ctrl_next[CTRL_FAST]  = 1'b0;
      end
    end else if (wr && addr == ADDR_IRQ_MASK) begin
      mask_next = wdata[IRQ_W-1:0];
    end else if (wr && addr == ADDR_IRQ_STAT) begin
      stat_next = stat_reg & ~wdata[IRQ_W-1:0];
    end
    if (wait_next && (ctrl_next[CTRL_POS] | ctrl_next[CTRL_INTER] | ctrl_next[CTRL_FAST])) begin
      wait_next = 1'b0;
    end else if (wait_reg && tick) begin
      late_ms_next = late_ms_reg + 16'h1;
    end
    // Events set after clear so set wins
    if (rdy_s[1] && !rdy_d_reg) stat_next[IRQ_READY] = 1'b1;
    if (brk_s[1] && !brk_d_reg) stat_next[IRQ_BRAKE] = 1'b1;
    if (rdy_d_reg && !rdy_s[1] && ctrl_reg[CTRL_ENABLE]) stat_next[IRQ_FAULT] = 1'b1;
    if (wait_reg && late_ms_reg >= 16'(SEL_DEADLINE_MS)) begin
      stat_next[IRQ_LATE] = 1'b1;
      wait_next = 1'b0;
    end
    if (rd) begin
      if (addr == ADDR_CTRL) rdata_next = 32'(ctrl_reg);
      else if (addr == ADDR_STATUS) rdata_next = {30'h0, brk_s[1], rdy_s[1]};
      else if (addr == ADDR_IRQ_STAT) rdata_next = 32'(stat_reg);
      else if (addr == ADDR_IRQ_MASK) rdata_next = 32'(mask_reg);
      else rdata_next = 32'h0;
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_reg    <= '0;
      stat_reg    <= '0;
      mask_reg    <= '0;
      rdata_reg   <= 32'h0;
      irq_reg     <= 1'b0;
      rdy_d_reg   <= 1'b0;
      brk_d_reg   <= 1'b0;
      late_ms_reg <= 16'h0;
      wait_reg    <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      stat_reg    <= stat_next;
      mask_reg    <= mask_next;
      rdata_reg   <= rdata_next;
      irq_reg     <= irq_next;
      rdy_d_reg   <= rdy_s[1];
      brk_d_reg   <= brk_s[1];
      late_ms_reg <= late_ms_next;
      wait_reg    <= wait_next;
    end
  end

  // Discrete and protocol pictures of the same command
  assign link.controller_enable_in       = ctrl_reg[CTRL_ENABLE];
  assign link.travel_direction_in        = ctrl_reg[CTRL_DIR];
  assign link.hold_zero_in               = ctrl_reg[CTRL_HOLD];
  assign link.positioning_speed_sel      = ctrl_reg[CTRL_POS];
  assign link.intermediate_speed_sel     = ctrl_reg[CTRL_INTER];
  assign link.fast_speed_sel             = ctrl_reg[CTRL_FAST];
  assign link.readjust_speed_sel         = ctrl_reg[CTRL_READJ];
  assign link.proto_mode                 = ctrl_reg[CTRL_PROTO];
  assign link.zero_speed_cmd_bit         = ctrl_reg[CTRL_HOLD];
  assign link.intermediate_speed_cmd_bit = ctrl_reg[CTRL_INTER];
  assign link.fast_speed_cmd_bit         = ctrl_reg[CTRL_FAST];
  assign link.travel_command_bit         = ctrl_reg[CTRL_ENABLE];
  assign link.off_switch_bit             = ctrl_reg[CTRL_ENABLE];
  assign link.travelling_speed_bit       = ctrl_reg[CTRL_ENABLE];
  assign link.travel_direction_bit       = ctrl_reg[CTRL_DIR];
  assign rdata                           = rdata_reg;
  assign irq                             = irq_reg;
endmodule : lift_controller

// ===== ms_tick.sv
// Millisecond enable pulse divider
`timescale 1ns/1ps
module ms_tick
  import quickstart_pkg::*;
#(
  parameter int unsigned DIV = MS_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  output logic      tick
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        tick_reg;
  logic        tick_next;

  always_comb begin
    tick_next = 1'b0;
    cnt_next  = cnt_reg + 32'h1;
    if (cnt_reg >= DIV - 1) begin
      cnt_next  = 32'h0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_reg  <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule : ms_tick

// ===== quickstart_drive.sv
// Drive end: quickstart sequencer with hold supervision
`timescale 1ns/1ps
module quickstart_drive
  import quickstart_pkg::*;
#(
  parameter int unsigned HOLD_LIMIT_CYC = HOLD_LIMIT_MS,
  parameter int unsigned TICK_DIV       = MS_CYCLES,
  parameter int unsigned ENC_TIME_MS    = ENC_SUPER_TIME_MS
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  quickstart_if.drive            link,
  input  wire logic              hold_input_configured,
  input  wire logic signed [POS_W-1:0] motor_position,
  input  wire logic              motor_moving,
  input  wire logic              fault_clear,
  output logic                   motor_energized,
  output logic                   zero_speed_regulate,
  output logic [1:0]             speed_select,
  output logic                   encoder_supervision_active,
  output logic                   encoder_fault,
  output logic [FAULT_W-1:0]     fault_code
);
  logic tick;
  ms_tick #(.DIV(TICK_DIV)) u_tick (.clk_sys(clk_sys), .srst(srst), .tick(tick));

  // Two-flop synchronisers for the pin-side inputs
  localparam int unsigned NIN = 15;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  assign raw_in = {link.controller_enable_in, link.travel_direction_in, link.hold_zero_in,
                   link.positioning_speed_sel, link.intermediate_speed_sel, link.fast_speed_sel,
                   link.readjust_speed_sel, link.proto_mode, link.zero_speed_cmd_bit,
                   link.intermediate_speed_cmd_bit, link.fast_speed_cmd_bit,
                   link.travel_command_bit, link.off_switch_bit, link.travelling_speed_bit,
                   link.travel_direction_bit};
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
    end
  end

  logic proto;
  logic hold_req;
  logic start_req;
  logic any_speed;
  logic readj;
  assign proto = s2_reg[7];
  // Discrete or protocol view of the start and hold requests
  assign start_req = proto ? (s2_reg[2] & s2_reg[3] & s2_reg[1] & s2_reg[0])
                           : (s2_reg[14] & s2_reg[13]);
  assign hold_req  = hold_input_configured & (proto ? s2_reg[6] : s2_reg[12]);
  assign readj     = ~proto & s2_reg[8];
  assign any_speed = proto ? (s2_reg[1] & (s2_reg[5] | s2_reg[4]))
                           : (s2_reg[11] | s2_reg[10] | s2_reg[9] | readj);

  drive_state_t          st_reg, st_next;
  logic [31:0]           hold_ms_reg, hold_ms_next;
  logic [31:0]           enc_ms_reg, enc_ms_next;
  logic signed [POS_W-1:0] anchor_reg, anchor_next;
  logic [FAULT_W-1:0]    fault_reg, fault_next;
  logic [1:0]            spd_reg, spd_next;
  logic                  rdy_reg, rdy_next, brk_reg, brk_next, en_reg, en_next;
  logic                  zero_reg, zero_next, encact_reg, encact_next, encflt_reg, encflt_next;
  logic signed [POS_W-1:0] delta;

  assign delta = motor_position - anchor_reg;

  always_comb begin
    st_next     = st_reg;
    hold_ms_next = hold_ms_reg;
    enc_ms_next = enc_ms_reg;
    anchor_next = anchor_reg;
    fault_next  = fault_reg;
    spd_next    = spd_reg;
    encact_next = encact_reg;
    encflt_next = encflt_reg;
    // Readjust beats fast beats intermediate beats positioning
    if (readj) spd_next = 2'h3;
    else if (proto ? s2_reg[4] : s2_reg[9]) spd_next = 2'h2;
    else if (proto ? s2_reg[5] : s2_reg[10]) spd_next = 2'h1;
    else spd_next = 2'h0;
    case (st_reg)
      ST_IDLE: begin
        encact_next = 1'b0;
        if (start_req && hold_req) begin
          st_next     = ST_ENERGIZE;
          anchor_next = motor_position;
        end else if (start_req && any_speed) begin
          st_next = ST_TRAVEL;
        end
      end
      ST_ENERGIZE: begin
        st_next      = ST_HOLD;
        hold_ms_next = 32'h0;
      end
      ST_HOLD: begin
        if (tick) hold_ms_next = hold_ms_reg + 32'h1;
        if (!start_req) st_next = ST_IDLE;
        else if (hold_ms_reg >= HOLD_LIMIT_CYC) begin
          st_next = ST_FAULT;
          fault_next[FLT_TIME_LIMIT] = 1'b1;
        end else if (delta > $signed(POS_W'(CREEP_LIMIT_MM)) ||
                     delta < -$signed(POS_W'(CREEP_LIMIT_MM))) begin
          st_next = ST_FAULT;
          fault_next[FLT_CREEP] = 1'b1;
        end else if (!hold_req) begin
          st_next     = ST_WAIT_SEL;
          enc_ms_next = 32'h0;
          encact_next = 1'b1;
        end
      end
      ST_WAIT_SEL, ST_TRAVEL: begin
        if (tick && encact_reg) enc_ms_next = enc_ms_reg + 32'h1;
        if (encact_reg && motor_moving) encact_next = 1'b0;
        else if (encact_reg && enc_ms_reg >= ENC_TIME_MS) encflt_next = 1'b1;
        if (!start_req) st_next = ST_IDLE;
        else if (hold_req) begin
          st_next = ST_FAULT;
          fault_next[FLT_DURING_TRAVEL] = 1'b1;
        end else if (any_speed) st_next = ST_TRAVEL;
      end
      ST_FAULT: begin
        encact_next = 1'b0;
        if (fault_clear) begin
          st_next    = ST_IDLE;
          fault_next = '0;
          encflt_next = 1'b0;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    // Outputs follow the next state
    rdy_next  = (st_next != ST_IDLE) && (st_next != ST_FAULT);
    en_next   = rdy_next;
    brk_next  = rdy_next && (st_next != ST_ENERGIZE);
    zero_next = (st_next == ST_HOLD) || (st_next == ST_ENERGIZE) || (st_next == ST_WAIT_SEL);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_reg      <= ST_IDLE;
      hold_ms_reg <= 32'h0;
      enc_ms_reg  <= 32'h0;
      anchor_reg  <= '0;
      fault_reg   <= '0;
      spd_reg     <= 2'h0;
      rdy_reg     <= 1'b0;
      brk_reg     <= 1'b0;
      en_reg      <= 1'b0;
      zero_reg    <= 1'b0;
      encact_reg  <= 1'b0;
      encflt_reg  <= 1'b0;
    end else begin
      st_reg      <= st_next;
      hold_ms_reg <= hold_ms_next;
      enc_ms_reg  <= enc_ms_next;
      anchor_reg  <= anchor_next;
      fault_reg   <= fault_next;
      spd_reg     <= spd_next;
      rdy_reg     <= rdy_next;
      brk_reg     <= brk_next;
      en_reg      <= en_next;
      zero_reg    <= zero_next;
      encact_reg  <= encact_next;
      encflt_reg  <= encflt_next;
    end
  end

  assign link.drive_ready_out          = rdy_reg;
  assign link.brake_release_out        = brk_reg;
  assign link.travel_active_status_bit = rdy_reg;
  assign link.brake_status_bit         = brk_reg;
  assign motor_energized               = en_reg;
  assign zero_speed_regulate           = zero_reg;
  assign speed_select                  = spd_reg;
  assign encoder_supervision_active    = encact_reg;
  assign encoder_fault                 = encflt_reg;
  assign fault_code                    = fault_reg;
endmodule : quickstart_drive

// ===== quickstart_if.sv
// Discrete and protocol signals between lift controller and drive
`timescale 1ns/1ps
interface quickstart_if;
  logic controller_enable_in;
  logic travel_direction_in;
  logic hold_zero_in;
  logic positioning_speed_sel;
  logic intermediate_speed_sel;
  logic fast_speed_sel;
  logic readjust_speed_sel;
  logic proto_mode;
  logic zero_speed_cmd_bit;
  logic intermediate_speed_cmd_bit;
  logic fast_speed_cmd_bit;
  logic travel_command_bit;
  logic off_switch_bit;
  logic travelling_speed_bit;
  logic travel_direction_bit;
  logic drive_ready_out;
  logic brake_release_out;
  logic travel_active_status_bit;
  logic brake_status_bit;

  modport drive (
    input  controller_enable_in, travel_direction_in, hold_zero_in, positioning_speed_sel,
           intermediate_speed_sel, fast_speed_sel, readjust_speed_sel, proto_mode,
           zero_speed_cmd_bit, intermediate_speed_cmd_bit, fast_speed_cmd_bit,
           travel_command_bit, off_switch_bit, travelling_speed_bit, travel_direction_bit,
    output drive_ready_out, brake_release_out, travel_active_status_bit, brake_status_bit
  );
  modport lift (
    output controller_enable_in, travel_direction_in, hold_zero_in, positioning_speed_sel,
           intermediate_speed_sel, fast_speed_sel, readjust_speed_sel, proto_mode,
           zero_speed_cmd_bit, intermediate_speed_cmd_bit, fast_speed_cmd_bit,
           travel_command_bit, off_switch_bit, travelling_speed_bit, travel_direction_bit,
    input  drive_ready_out, brake_release_out, travel_active_status_bit, brake_status_bit
  );
endinterface : quickstart_if

// ===== quickstart_pkg.sv
// Shared constants and types for the quickstart drive link
package quickstart_pkg;
  localparam int unsigned CLK_HZ            = 100_000_000;
  localparam int unsigned HOLD_LIMIT_MS     = 20_000;
  localparam int unsigned SEL_DEADLINE_MS   = 150;
  localparam int unsigned CREEP_LIMIT_MM    = 7;
  localparam int unsigned ENC_SUPER_TIME_MS = 2_000;
  localparam int unsigned MS_CYCLES         = CLK_HZ / 1000;
  localparam int unsigned POS_W             = 16;
  localparam int unsigned FAULT_W           = 3;
  localparam int unsigned FLT_TIME_LIMIT    = 0;
  localparam int unsigned FLT_DURING_TRAVEL = 1;
  localparam int unsigned FLT_CREEP         = 2;
  localparam logic [3:0]  ADDR_CTRL         = 4'h0;
  localparam logic [3:0]  ADDR_STATUS       = 4'h1;
  localparam logic [3:0]  ADDR_IRQ_STAT     = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_MASK     = 4'h3;
  localparam logic [3:0]  ADDR_FAULT        = 4'h4;
  localparam int unsigned CTRL_ENABLE       = 0;
  localparam int unsigned CTRL_DIR          = 1;
  localparam int unsigned CTRL_HOLD         = 2;
  localparam int unsigned CTRL_POS          = 3;
  localparam int unsigned CTRL_INTER        = 4;
  localparam int unsigned CTRL_FAST         = 5;
  localparam int unsigned CTRL_READJ        = 6;
  localparam int unsigned CTRL_PROTO        = 7;
  localparam int unsigned CTRL_W            = 8;
  localparam int unsigned IRQ_W             = 4;
  localparam int unsigned IRQ_READY         = 0;
  localparam int unsigned IRQ_BRAKE         = 1;
  localparam int unsigned IRQ_FAULT         = 2;
  localparam int unsigned IRQ_LATE          = 3;

  typedef enum logic [5:0] {
    ST_IDLE     = 6'b000001,
    ST_ENERGIZE = 6'b000010,
    ST_HOLD     = 6'b000100,
    ST_WAIT_SEL = 6'b001000,
    ST_TRAVEL   = 6'b010000,
    ST_FAULT    = 6'b100000
  } drive_state_t;
endpackage : quickstart_pkg

// ===== quickstart_props.sv
// Assertions on the quickstart link between lift controller and drive
`timescale 1ns/1ps
module quickstart_props #(
  parameter int unsigned HOLD_MAX = 100
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic controller_enable_in,
  input wire logic hold_zero_in,
  input wire logic positioning_speed_sel,
  input wire logic intermediate_speed_sel,
  input wire logic fast_speed_sel,
  input wire logic proto_mode,
  input wire logic zero_speed_cmd_bit,
  input wire logic drive_ready_out,
  input wire logic brake_release_out,
  input wire logic travel_active_status_bit,
  input wire logic brake_status_bit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  logic [15:0] hold_cnt_reg;
  logic [15:0] hold_cnt_next;

  // Cycles of brake open while zero speed is held
  always_comb begin
    hold_cnt_next = 16'h0000;
    if (brake_release_out && (proto_mode ? zero_speed_cmd_bit : hold_zero_in)) begin
      hold_cnt_next = hold_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    hold_cnt_reg <= srst ? 16'h0000 : hold_cnt_next;
  end

  ready_needs_enable_a: assert property ($rose(drive_ready_out) && !proto_mode |-> $past(controller_enable_in, 2))
    else $error("ready rose without enable");
  brake_after_ready_a: assert property ($rose(brake_release_out) |-> $past(drive_ready_out))
    else $error("brake opened before ready");
  brake_within_ready_a: assert property (brake_release_out |-> drive_ready_out)
    else $error("brake open without ready");
  active_with_ready_a: assert property ($rose(drive_ready_out) |-> travel_active_status_bit)
    else $error("travel active missing at ready");
  brake_status_order_a: assert property ($rose(brake_status_bit) |-> travel_active_status_bit && brake_release_out)
    else $error("brake status out of order");
  hold_in_travel_a: assert property ($rose(hold_zero_in) && drive_ready_out && !proto_mode
    && $past(positioning_speed_sel || intermediate_speed_sel || fast_speed_sel) |-> ##[1:8] !drive_ready_out)
    else $error("hold during travel not faulted");
  hold_limit_a: assert property (hold_cnt_reg <= HOLD_MAX)
    else $error("zero speed held too long");
  speed_after_hold_a: assert property (hold_zero_in |-> !(positioning_speed_sel || intermediate_speed_sel || fast_speed_sel))
    else $error("speed selected while hold set");
endmodule : quickstart_props

// ===== tb_top.sv
// Self-checking bench for lift controller and quickstart drive
`timescale 1ns/1ps
module tb_top
  import quickstart_pkg::*;
;
  logic                    clk_sys = 1'b0;
  logic                    srst = 1'b1;
  logic [3:0]              addr = 4'h0;
  logic [31:0]             wdata = 32'h0;
  logic                    wr = 1'b0;
  logic                    rd = 1'b0;
  logic                    hold_cfg = 1'b1;
  logic signed [POS_W-1:0] motor_position = '0;
  logic                    motor_moving = 1'b0;
  logic                    fault_clear = 1'b0;
  logic [31:0]             rdata;
  logic                    irq;
  logic                    energized;
  logic                    zreg;
  logic [1:0]              spd;
  logic                    enc_act;
  logic                    enc_flt;
  logic [FAULT_W-1:0]      fcode;
  logic [31:0]             got;
  logic [7:0]              ctl_tab [4] = '{8'h0B, 8'h13, 8'h23, 8'h7B};
  logic [1:0]              spd_tab [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  int                      n;
  int                      n_mismatch = 0;
  int                      checks = 0;

  quickstart_if lnk ();
  quickstart_drive #(.HOLD_LIMIT_CYC(20), .TICK_DIV(4), .ENC_TIME_MS(5)) quickstart_drive_inst (
    .clk_sys(clk_sys), .srst(srst), .link(lnk.drive), .hold_input_configured(hold_cfg),
    .motor_position(motor_position), .motor_moving(motor_moving), .fault_clear(fault_clear),
    .motor_energized(energized), .zero_speed_regulate(zreg), .speed_select(spd),
    .encoder_supervision_active(enc_act), .encoder_fault(enc_flt), .fault_code(fcode));
  lift_controller #(.TICK_DIV(4)) lift_controller_inst (
    .clk_sys(clk_sys), .srst(srst), .link(lnk.lift), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq));
  quickstart_props #(.HOLD_MAX(100)) quickstart_props_inst (
    .clk_sys(clk_sys), .srst(srst), .controller_enable_in(lnk.controller_enable_in),
    .hold_zero_in(lnk.hold_zero_in), .positioning_speed_sel(lnk.positioning_speed_sel),
    .intermediate_speed_sel(lnk.intermediate_speed_sel), .fast_speed_sel(lnk.fast_speed_sel),
    .proto_mode(lnk.proto_mode), .zero_speed_cmd_bit(lnk.zero_speed_cmd_bit),
    .drive_ready_out(lnk.drive_ready_out), .brake_release_out(lnk.brake_release_out),
    .travel_active_status_bit(lnk.travel_active_status_bit), .brake_status_bit(lnk.brake_status_bit));

  always #5 clk_sys = ~clk_sys;

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : bus_rd

  task automatic wait_sig(input logic brk, input logic lvl, input int lim);
    n = 0;
    while ((brk ? lnk.brake_release_out : lnk.drive_ready_out) !== lvl && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(brk ? "brake" : "ready", lvl, brk ? lnk.brake_release_out : lnk.drive_ready_out);
  endtask : wait_sig

  task automatic recover();
    bus_wr(ADDR_CTRL, 32'h0);
    @(posedge clk_sys);
    fault_clear <= 1'b1;
    repeat (4) @(posedge clk_sys);
    fault_clear <= 1'b0;
    bus_wr(ADDR_IRQ_STAT, 32'hF);
  endtask : recover

  initial begin
    repeat (10000) @(posedge clk_sys);
    n_mismatch++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    bus_rd(ADDR_STATUS, got);
    chk("status after reset", 0, got);
    bus_rd(4'hF, got);
    chk("unmapped read", 0, got);
    $display("reset test done");
    bus_wr(ADDR_IRQ_MASK, 32'hF);
    bus_wr(ADDR_CTRL, 32'h07);
    wait_sig(0, 1, 20);
    chk("energized", 1, energized);
    wait_sig(1, 1, 3);
    chk("brake delay", 1, n);
    chk("zero regulate", 1, zreg);
    chk("encoder idle in hold", 0, enc_act);
    repeat (4) @(posedge clk_sys);
    bus_rd(ADDR_IRQ_STAT, got);
    chk("irq status", 3, got);
    chk("irq line", 1, irq);
    bus_wr(ADDR_IRQ_STAT, 32'h3);
    bus_rd(ADDR_IRQ_STAT, got);
    chk("irq cleared", 0, {got[31:1], irq});
    bus_wr(ADDR_CTRL, 32'h23);
    repeat (4) @(posedge clk_sys);
    #1;
    chk("encoder started", 1, enc_act);
    motor_moving <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus_wr(ADDR_CTRL, {24'h0, ctl_tab[i]});
      repeat (6) @(posedge clk_sys);
      #1;
      chk("speed select", spd_tab[i], spd);
    end
    $display("discrete start test done");
    bus_wr(ADDR_IRQ_STAT, 32'hF);
    bus_wr(ADDR_IRQ_MASK, 32'hB);
    bus_wr(ADDR_CTRL, 32'h07);
    wait_sig(0, 0, 20);
    chk("fault code", 3'b010, fcode);
    chk("brake off", 0, lnk.brake_release_out);
    chk("motor off", 0, energized);
    repeat (4) @(posedge clk_sys);
    bus_rd(ADDR_IRQ_STAT, got);
    chk("drop flag masked", 32'h4, {got[31:1], irq});
    bus_wr(ADDR_IRQ_MASK, 32'hF);
    bus_rd(ADDR_IRQ_STAT, got);
    chk("irq unmasked", 1, irq);
    bus_wr(ADDR_IRQ_STAT, 32'h4);
    bus_rd(ADDR_IRQ_STAT, got);
    chk("drop flag cleared", 0, {got[31:1], irq});
    recover();
    motor_moving <= 1'b0;
    $display("travel fault test done");
    bus_wr(ADDR_CTRL, 32'h07);
    wait_sig(1, 1, 20);
    wait_sig(1, 0, 200);
    chk("hold span", 1, (n >= 70 && n <= 90));
    chk("fault code", 3'b001, fcode);
    recover();
    $display("hold limit test done");
    bus_wr(ADDR_CTRL, 32'h07);
    wait_sig(1, 1, 20);
    @(posedge clk_sys);
    motor_position <= 16'sd7;
    repeat (8) @(posedge clk_sys);
    #1;
    chk("creep at limit", 1, lnk.drive_ready_out);
    @(posedge clk_sys);
    motor_position <= 16'sd8;
    wait_sig(0, 0, 10);
    chk("fault code", 3'b100, fcode);
    recover();
    motor_position <= '0;
    $display("creep test done");
    hold_cfg <= 1'b0;
    bus_wr(ADDR_CTRL, 32'h07);
    repeat (20) @(posedge clk_sys);
    #1;
    chk("hold refused", 0, {lnk.brake_release_out, zreg});
    recover();
    hold_cfg <= 1'b1;
    $display("unconfigured hold test done");
    motor_moving <= 1'b1;
    bus_wr(ADDR_CTRL, 32'h07);
    wait_sig(1, 1, 20);
    bus_wr(ADDR_IRQ_STAT, 32'hF);
    bus_wr(ADDR_CTRL, 32'h03);
    repeat (560) @(posedge clk_sys);
    bus_rd(ADDR_IRQ_STAT, got);
    chk("late flag early", 0, got[IRQ_LATE]);
    repeat (100) @(posedge clk_sys);
    bus_rd(ADDR_IRQ_STAT, got);
    chk("late flag", 1, got[IRQ_LATE]);
    recover();
    motor_moving <= 1'b0;
    $display("speed deadline test done");
    bus_wr(ADDR_CTRL, 32'h87);
    wait_sig(0, 1, 20);
    chk("travel active", 1, lnk.travel_active_status_bit);
    chk("start bits", 5'h1F, {lnk.zero_speed_cmd_bit, lnk.travel_command_bit, lnk.off_switch_bit,
      lnk.travelling_speed_bit, lnk.travel_direction_bit});
    wait_sig(1, 1, 3);
    chk("brake status", 1, lnk.brake_status_bit);
    chk("zero regulate", 1, zreg);
    bus_wr(ADDR_CTRL, 32'hA3);
    repeat (4) @(posedge clk_sys);
    #1;
    chk("speed bits", 3'b110, {lnk.fast_speed_cmd_bit, lnk.travelling_speed_bit, lnk.zero_speed_cmd_bit});
    repeat (30) @(posedge clk_sys);
    #1;
    chk("encoder fault", 1, enc_flt);
    $display("protocol test done");
    close_out();
  end
endmodule : tb_top
